// ==== rtl/flash_if_defines.vh ====
// Constants for the on-chip flash program interface: map, register layout, commands, timing.
// Assumes a 40 MHz core clock; counts are derived from the times printed beside them.
`ifndef FLASH_IF_DEFINES_VH
`define FLASH_IF_DEFINES_VH

// Clock period in nanoseconds.
`define CLK_PERIOD_NS      25
// Flash window in the CPU map and array size.
`define FLASH_BASE         16'h8000
`define FLASH_AW           15
`define FLASH_WORDS        32768
// Control/status register address and bit positions.
`define CTRL_ADDR          16'h007A
`define CTRL_IRQ_EN_BIT    7
`define CTRL_IRQ_FLAG_BIT  6
`define CTRL_WR_EN_BIT     5
`define CTRL_READY_BIT     4
`define CTRL_RSV_MASK      8'h0D
`define CTRL_RESET         8'h00
// Sector selection: bit 14 picks the 16 KB sector, bit 13 splits the two 8 KB sectors.
`define SECTOR_HI_BIT      14
`define SECTOR_MID_BIT     13
`define SECTOR_ALL         3'h7
// Command sequence addresses (low 12 address bits) and data codes.
`define UNLOCK_ADDR1       12'hAAA
`define UNLOCK_ADDR2       12'h555
`define CMD_UNLOCK1        8'hAA
`define CMD_UNLOCK2        8'h55
`define CMD_PROGRAM        8'hA0
`define CMD_ERASE_SETUP    8'h80
`define CMD_CHIP_ERASE     8'h10
`define CMD_SECTOR_ERASE   8'h30
`define CMD_SUSPEND        8'hB0
`define CMD_RESUME         8'h30
`define CMD_RESET          8'hF0
`define ERASED_BYTE        8'hFF
// Times in microseconds, and the derived cycle counts (least times round up).
`define T_PROG_US          16
`define T_SECT_WINDOW_US   50
`define T_ERASE_US         1000
`define PROG_CYC    ((`T_PROG_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WINDOW_CYC  ((`T_SECT_WINDOW_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYC   ((`T_ERASE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== rtl/onchip_flash_program_interface.v ====
// Flash interface between the 8-bit CPU core and a 32 KB on-chip flash array.
// Assumes the CPU bus is synchronous to clk_in and that read strobes last one cycle.
//
// Contract
// - Flash occupies CPU addresses 8000 to FFFF.
// - Plain reads behave like mask ROM.
// - Only CPU command writes start program/erase.
// - Array is 32 KB of bytes.
// - Sectors C000-FFFF, A000-BFFF, 8000-9FFF.
// - Program and erase timing run automatically.
// - Commands use JEDEC unlock write sequences.
// - Erase can be suspended and resumed.
// - Reads while busy show polling, toggle bits.
// - Completion can raise a CPU interrupt.
// - Sector erase takes any sector combination.
// - Control/status register at 007A, fixed layout.
`timescale 1ns/1ps
`include "flash_if_defines.vh"

module onchip_flash_program_interface #(
    parameter integer ERASE_CYC = `ERASE_CYC
) (
    // Clock and reset.
    input  wire        clk_in,
    input  wire        rst_n_in,
    // CPU bus.
    input  wire [15:0] cpu_addr_in,
    input  wire [7:0]  cpu_wdata_in,
    input  wire        cpu_rd_in,
    input  wire        cpu_wr_in,
    output reg  [7:0]  cpu_rdata_out,
    // Completion interrupt request.
    output reg         irq_out
);

    // Counts are cut to the 16-bit timer width on purpose; every one of them fits.
    localparam integer PROG_CYC_I   = `PROG_CYC;
    localparam integer WINDOW_CYC_I = `WINDOW_CYC;
    localparam [15:0]  PROG_CYC     = PROG_CYC_I[15:0];
    localparam [15:0]  WINDOW_CYC   = WINDOW_CYC_I[15:0];
    localparam [15:0]  ERASE_LAST   = ERASE_CYC[15:0] - 16'h0001;

    // Algorithm states.
    localparam [2:0] ST_IDLE   = 3'd0;
    localparam [2:0] ST_PROG   = 3'd1;
    localparam [2:0] ST_WINDOW = 3'd2;
    localparam [2:0] ST_ERASE  = 3'd3;
    localparam [2:0] ST_SWEEP  = 3'd4;
    localparam [2:0] ST_SUSP   = 3'd5;

    // Command sequence steps.
    localparam [2:0] SQ_IDLE   = 3'd0;
    localparam [2:0] SQ_UNL1   = 3'd1;
    localparam [2:0] SQ_UNL2   = 3'd2;
    localparam [2:0] SQ_PDATA  = 3'd3;
    localparam [2:0] SQ_EUNL0  = 3'd4;
    localparam [2:0] SQ_EUNL1  = 3'd5;
    localparam [2:0] SQ_ESEL   = 3'd6;

    // The array itself; it has no reset because flash keeps its contents.
    reg [7:0] mem [0:`FLASH_WORDS-1];

    reg [2:0]             state_r;
    reg [2:0]             seq_r;
    reg [15:0]            cnt_r;
    reg [`FLASH_AW-1:0]   sweep_r;
    reg [2:0]             sectors_r;
    reg [`FLASH_AW-1:0]   prog_addr_r;
    reg [7:0]             prog_data_r;
    reg                   toggle_r;
    reg                   irq_en_r;
    reg                   irq_flag_r;
    reg                   wr_en_r;
    reg [2:0]             rsv_r;

    wire                  in_flash;
    wire                  ctrl_hit;
    wire                  cmd_wr;
    wire [11:0]           low_addr;
    wire [2:0]            addr_sector;
    wire                  busy;
    wire                  done_evt;
    wire                  prog_commit;
    wire                  sweep_write;
    wire                  sweep_last;
    wire [7:0]            status_byte;
    wire [7:0]            ctrl_byte;

    // Sector one-hot from a flash offset: bit 2 is the 16 KB sector.
    function [2:0] sector_of;
        input [`FLASH_AW-1:0] a;
        begin
            if (a[`SECTOR_HI_BIT]) begin
                sector_of = 3'b100;
            end else if (a[`SECTOR_MID_BIT]) begin
                sector_of = 3'b010;
            end else begin
                sector_of = 3'b001;
            end
        end
    endfunction

    // Address decode; the top half of the map is flash, the register sits in I/O space.
    assign in_flash    = cpu_addr_in[15] == `FLASH_BASE >> 15;
    assign ctrl_hit    = cpu_addr_in == `CTRL_ADDR;
    assign cmd_wr      = cpu_wr_in && in_flash && wr_en_r;
    assign low_addr    = cpu_addr_in[11:0];
    assign addr_sector = sector_of(cpu_addr_in[`FLASH_AW-1:0]);
    assign busy        = state_r != ST_IDLE && state_r != ST_SUSP;
    assign prog_commit = state_r == ST_PROG && cnt_r == PROG_CYC - 16'd1;
    assign sweep_write = state_r == ST_SWEEP && (sectors_r & sector_of(sweep_r)) != 3'b000;
    assign sweep_last  = state_r == ST_SWEEP && sweep_r == {`FLASH_AW{1'b1}};
    assign done_evt    = prog_commit || sweep_last;

    // Polling byte: bit 7 is inverted program data (0 while erasing), bit 6 toggles per read while busy.
    assign status_byte = {(state_r == ST_PROG) ? ~prog_data_r[7] : 1'b0,
                          toggle_r, 6'h00};
    assign ctrl_byte   = {irq_en_r, irq_flag_r, wr_en_r, ~busy,
                          rsv_r[2], rsv_r[1], 1'b0, rsv_r[0]};

    // Algorithm state machine and command decoder share one process so that a
    // command and the end of an algorithm can never fight over the state.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r     <= ST_IDLE;
            seq_r       <= SQ_IDLE;
            cnt_r       <= 16'h0000;
            sweep_r     <= {`FLASH_AW{1'b0}};
            sectors_r   <= 3'b000;
            prog_addr_r <= {`FLASH_AW{1'b0}};
            prog_data_r <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= 16'h0000;
                    if (cmd_wr) begin
                        // Program data is any byte, so the reset code only counts between steps.
                        if (cpu_wdata_in == `CMD_RESET && seq_r != SQ_PDATA) begin
                            seq_r <= SQ_IDLE;
                        end else begin
                            case (seq_r)
                                SQ_IDLE: begin
                                    seq_r <= (low_addr == `UNLOCK_ADDR1 &&
                                              cpu_wdata_in == `CMD_UNLOCK1) ? SQ_UNL1 : SQ_IDLE;
                                end
                                SQ_UNL1: begin
                                    seq_r <= (low_addr == `UNLOCK_ADDR2 &&
                                              cpu_wdata_in == `CMD_UNLOCK2) ? SQ_UNL2 : SQ_IDLE;
                                end
                                SQ_UNL2: begin
                                    if (low_addr == `UNLOCK_ADDR1 &&
                                        cpu_wdata_in == `CMD_PROGRAM) begin
                                        seq_r <= SQ_PDATA;
                                    end else if (low_addr == `UNLOCK_ADDR1 &&
                                                 cpu_wdata_in == `CMD_ERASE_SETUP) begin
                                        seq_r <= SQ_EUNL0;
                                    end else begin
                                        seq_r <= SQ_IDLE;
                                    end
                                end
                                SQ_PDATA: begin
                                    // Program data write starts the timed algorithm.
                                    prog_addr_r <= cpu_addr_in[`FLASH_AW-1:0];
                                    prog_data_r <= cpu_wdata_in;
                                    state_r     <= ST_PROG;
                                    seq_r       <= SQ_IDLE;
                                end
                                SQ_EUNL0: begin
                                    seq_r <= (low_addr == `UNLOCK_ADDR1 &&
                                              cpu_wdata_in == `CMD_UNLOCK1) ? SQ_EUNL1 : SQ_IDLE;
                                end
                                SQ_EUNL1: begin
                                    seq_r <= (low_addr == `UNLOCK_ADDR2 &&
                                              cpu_wdata_in == `CMD_UNLOCK2) ? SQ_ESEL : SQ_IDLE;
                                end
                                SQ_ESEL: begin
                                    seq_r <= SQ_IDLE;
                                    if (cpu_wdata_in == `CMD_SECTOR_ERASE) begin
                                        sectors_r <= addr_sector;
                                        state_r   <= ST_WINDOW;
                                    end else if (low_addr == `UNLOCK_ADDR1 &&
                                                 cpu_wdata_in == `CMD_CHIP_ERASE) begin
                                        sectors_r <= `SECTOR_ALL;
                                        state_r   <= ST_ERASE;
                                    end
                                end
                                default: begin
                                    seq_r <= SQ_IDLE;
                                end
                            endcase
                        end
                    end
                end
                ST_PROG: begin
                    // Commands are ignored until the program pulse ends.
                    cnt_r <= cnt_r + 16'd1;
                    if (prog_commit) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_WINDOW: begin
                    // Each further sector command adds a sector and restarts the window.
                    if (cmd_wr && cpu_wdata_in == `CMD_SECTOR_ERASE) begin
                        sectors_r <= sectors_r | addr_sector;
                        cnt_r     <= 16'h0000;
                    end else if (cnt_r == WINDOW_CYC - 16'd1) begin
                        cnt_r   <= 16'h0000;
                        state_r <= ST_ERASE;
                    end else begin
                        cnt_r <= cnt_r + 16'd1;
                    end
                end
                ST_ERASE: begin
                    if (cmd_wr && cpu_wdata_in == `CMD_SUSPEND) begin
                        state_r <= ST_SUSP;
                    end else if (cnt_r == ERASE_LAST) begin
                        sweep_r <= {`FLASH_AW{1'b0}};
                        state_r <= ST_SWEEP;
                    end else begin
                        cnt_r <= cnt_r + 16'd1;
                    end
                end
                ST_SWEEP: begin
                    // One byte per cycle is cleared to the erased value in the chosen sectors.
                    sweep_r <= sweep_r + {{(`FLASH_AW-1){1'b0}}, 1'b1};
                    if (sweep_last) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_SUSP: begin
                    // The erase timer holds its count, so resume continues where it stopped.
                    if (cmd_wr && cpu_wdata_in == `CMD_RESUME) begin
                        state_r <= ST_ERASE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Array writes: programming can only clear bits, erase sets whole bytes.
    always @(posedge clk_in) begin
        if (prog_commit) begin
            mem[prog_addr_r] <= mem[prog_addr_r] & prog_data_r;
        end else if (sweep_write) begin
            mem[sweep_r] <= `ERASED_BYTE;
        end
    end

    // CPU read path; data returns one cycle after the read strobe, like a ROM.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpu_rdata_out <= 8'h00;
            toggle_r      <= 1'b0;
        end else if (cpu_rd_in && ctrl_hit) begin
            cpu_rdata_out <= ctrl_byte;
        end else if (cpu_rd_in && in_flash) begin
            if (busy) begin
                cpu_rdata_out <= status_byte;
                toggle_r      <= ~toggle_r;
            end else if (state_r == ST_SUSP && (addr_sector & sectors_r) != 3'b000) begin
                // A sector caught mid-erase is not readable; report status instead.
                cpu_rdata_out <= status_byte;
            end else begin
                cpu_rdata_out <= mem[cpu_addr_in[`FLASH_AW-1:0]];
            end
        end else if (cpu_rd_in) begin
            cpu_rdata_out <= 8'h00;
        end
    end

    // Control/status register; a completion in the same cycle as a clear keeps the flag set.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_en_r   <= 1'b0;
            irq_flag_r <= 1'b0;
            wr_en_r    <= 1'b0;
            rsv_r      <= 3'b000;
            irq_out    <= 1'b0;
        end else begin
            if (cpu_wr_in && ctrl_hit) begin
                irq_en_r <= cpu_wdata_in[`CTRL_IRQ_EN_BIT];
                wr_en_r  <= cpu_wdata_in[`CTRL_WR_EN_BIT];
                rsv_r    <= {cpu_wdata_in[3], cpu_wdata_in[2], cpu_wdata_in[0]};
            end
            if (done_evt) begin
                irq_flag_r <= 1'b1;
            end else if (cpu_wr_in && ctrl_hit && !cpu_wdata_in[`CTRL_IRQ_FLAG_BIT]) begin
                irq_flag_r <= 1'b0;
            end
            irq_out <= irq_en_r && irq_flag_r;
        end
    end

endmodule

// ==== testbench/cpu_model.sv ====
// CPU bus model: one bus cycle per clock, issued from tasks.
// Assumes callers enter just after a rising edge of clk_in.
`timescale 1ns/1ps
module cpu_model (
    // Clock.
    input  wire        clk_in,
    // Bus strobes and payload.
    output reg  [15:0] cpu_addr_out,
    output reg  [7:0]  cpu_wdata_out,
    output reg         cpu_rd_out,
    output reg         cpu_wr_out
);
    // Quiet bus at time zero.
    initial begin
        cpu_rd_out = 1'b0;
        cpu_wr_out = 1'b0;
        cpu_addr_out = 16'h0000;
        cpu_wdata_out = 8'h00;
    end

    // The updater runs from RAM; the array is read both to poll status and to check programmed data.
    // Each signal changes once and holds through the sampling edge.
    // Only CPU addresses appear here; programmer aliases belong to an external writer.
    task op(input r, input w, input [15:0] a, input [7:0] d);
        begin
            cpu_rd_out = r;
            cpu_wr_out = w;
            cpu_addr_out = a;
            cpu_wdata_out = w ? d : ~cpu_wdata_out; // Idle data keeps moving.
            @(posedge clk_in);
            #1;
        end
    endtask
endmodule

// ==== testbench/flash_if_asserts.sv ====
// Port checker for the flash interface, bound into every instance.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module flash_if_checker #(
    parameter integer ERASE_CYC = 40000
) (
    // Clock and reset.
    input wire        clk_in,
    input wire        rst_n_in,
    // CPU bus.
    input wire [15:0] cpu_addr_in,
    input wire [7:0]  cpu_wdata_in,
    input wire        cpu_rd_in,
    input wire        cpu_wr_in,
    input wire [7:0]  cpu_rdata_out,
    input wire        irq_out
);
    reg en_r;

    // Shadow of the enable bit; a completion can never set it, only writes do.
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_r <= 1'b0;
        end else if (cpu_wr_in && cpu_addr_in == 16'h007A) begin
            en_r <= cpu_wdata_in[7];
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    reset_clear_a: assert property ($rose(rst_n_in) |-> cpu_rdata_out == 8'h00 && !irq_out)
        else $error("outputs not clear after reset");
    rdata_hold_a: assert property (!cpu_rd_in |=> $stable(cpu_rdata_out))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (cpu_rd_in && cpu_addr_in < 16'h8000
        && cpu_addr_in != 16'h007A |=> cpu_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    unused_bit_a: assert property (cpu_rd_in && cpu_addr_in == 16'h007A |=> !cpu_rdata_out[1])
        else $error("unused control bit read as one");
    ctrl_store_a: assert property (cpu_wr_in && cpu_addr_in == 16'h007A ##1 cpu_rd_in
        && cpu_addr_in == 16'h007A |=> (cpu_rdata_out & 8'hAD) == ($past(cpu_wdata_in, 2) & 8'hAD))
        else $error("control write not read back");
    ctrl_steady_a: assert property (cpu_rd_in && cpu_addr_in == 16'h007A ##1 cpu_rd_in
        && cpu_addr_in == 16'h007A |=> (cpu_rdata_out & 8'hAD) == ($past(cpu_rdata_out) & 8'hAD))
        else $error("control bits changed without a write");
    irq_off_a: assert property (cpu_wr_in && cpu_addr_in == 16'h007A && !cpu_wdata_in[7]
        |=> ##1 !irq_out)
        else $error("interrupt stayed up after disable");
    irq_enable_a: assert property (irq_out |-> $past(en_r))
        else $error("interrupt raised while disabled");
    irq_flag_read_a: assert property (cpu_rd_in && cpu_addr_in == 16'h007A && irq_out
        && !$past(cpu_wr_in) |=> cpu_rdata_out[7:6] == 2'b11)
        else $error("interrupt up without enable and flag");
endmodule

bind onchip_flash_program_interface flash_if_checker #(.ERASE_CYC(ERASE_CYC)) checker_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_addr_in(cpu_addr_in),
    .cpu_wdata_in(cpu_wdata_in), .cpu_rd_in(cpu_rd_in), .cpu_wr_in(cpu_wr_in),
    .cpu_rdata_out(cpu_rdata_out), .irq_out(irq_out));

// ==== testbench/testbench.sv ====
// Self-checking bench for the flash interface, driving it through the CPU model.
// Assumes the erase count is shortened to 200 cycles to keep the run brief.
`timescale 1ns/1ps
module testbench;
    reg         clk_in;
    reg         rst_n_in;
    wire [15:0] a;
    wire [7:0]  wd;
    wire [7:0]  rdata;
    wire        rd;
    wire        wr;
    wire        irq;
    integer     fails;
    integer     n_compared;
    integer     i;
    reg  [16:0] exp_q[$];
    reg  [16:0] e;
    reg  [7:0]  d;
    reg  [7:0]  d2;
    reg  [7:0]  prev;
    reg         seen;

    onchip_flash_program_interface #(.ERASE_CYC(200)) dut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .cpu_addr_in(a), .cpu_wdata_in(wd), .cpu_rd_in(rd),
        .cpu_wr_in(wr), .cpu_rdata_out(rdata), .irq_out(irq));
    cpu_model cpu (.clk_in(clk_in), .cpu_addr_out(a), .cpu_wdata_out(wd),
        .cpu_rd_out(rd), .cpu_wr_out(wr));

    // Clock at 40 MHz.
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Entry: bit 16 asks bit 6 to differ from the last read, 15:8 mask, 7:0 value.
    function [16:0] fx(input [7:0] v);
        fx = {1'b0, 8'hFF, v};
    endfunction

    task complete_run;
        begin
            $display("compared %0d fails %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask

    task check_rd(input [16:0] x);
        begin
            n_compared = n_compared + 1;
            if ((rdata & x[15:8]) !== x[7:0] || (x[16] && rdata[6] === prev[6])) begin
                fails = fails + 1;
                $display("unexpected cpu_rdata_out expected %h seen %h", x[7:0], rdata);
            end
        end
    endtask

    task check_irq(input v);
        begin
            n_compared = n_compared + 1;
            if (irq !== v) begin
                fails = fails + 1;
                $display("unexpected irq_out expected %b seen %b", v, irq);
            end
        end
    endtask

    // Read data lands one cycle after the strobe edge; compare mid-cycle.
    always @(posedge clk_in) seen <= rd;
    always @(negedge clk_in) begin
        if (seen === 1'b1) begin
            e = exp_q.pop_front();
            check_rd(e);
            prev = rdata;
        end
    end

    // The note goes on the queue before the strobe, so the watcher always finds it.
    task rdx(input [15:0] ad, input [16:0] x);
        begin
            exp_q.push_back(x);
            cpu.op(1'b1, 1'b0, ad, 8'h00);
        end
    endtask

    task unlock;
        begin
            cpu.op(1'b0, 1'b1, 16'h8AAA, 8'hAA);
            cpu.op(1'b0, 1'b1, 16'h8555, 8'h55);
        end
    endtask

    task prog(input [15:0] ad, input [7:0] v);
        begin
            unlock;
            cpu.op(1'b0, 1'b1, 16'h8AAA, 8'hA0);
            cpu.op(1'b0, 1'b1, ad, v);
        end
    endtask

    task erase(input [15:0] ad, input [7:0] v);
        begin
            unlock;
            cpu.op(1'b0, 1'b1, 16'h8AAA, 8'h80);
            unlock;
            cpu.op(1'b0, 1'b1, ad, v);
        end
    endtask

    // Bounded wait for completion; the bus idles meanwhile, then the flag is cleared when clr is set.
    task done(input clr);
        begin
            i = 0;
            while (irq !== 1'b1 && i < 40000) begin
                cpu.op(1'b0, 1'b0, 16'h0000, 8'h00);
                i = i + 1;
            end
            check_irq(1'b1);
            if (clr) begin
                cpu.op(1'b0, 1'b1, 16'h007A, 8'hA0);
                cpu.op(1'b0, 1'b0, 16'h0000, 8'h00);
                check_irq(1'b0);
            end
        end
    endtask

    // Watchdog sized above the two long erase sweeps.
    initial begin
        #2200000;
        fails = fails + 1;
        $display("unexpected watchdog expected done seen timeout");
        complete_run;
    end

    initial begin
        rst_n_in = 1'b0;
        fails = 0;
        n_compared = 0;
        seen = 1'b0;
        prev = 8'h00;
        i = $urandom(32'h254a);
        d = $urandom;
        d2 = $urandom;
        repeat (16) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        check_irq(1'b0);
        rdx(16'h007A, fx(8'h10));
        rdx(16'h007A, fx(8'h10));
        rdx(16'h0050, fx(8'h00));
        cpu.op(1'b0, 1'b1, 16'h007A, 8'hFF);
        rdx(16'h007A, fx(8'hBD));
        cpu.op(1'b0, 1'b1, 16'h007A, 8'h00);
        prog(16'hC000, 8'h00);
        rdx(16'h007A, fx(8'h10));
        cpu.op(1'b0, 1'b1, 16'h007A, 8'hA0);
        erase(16'h8AAA, 8'h10);
        rdx(16'h007A, fx(8'hA0));
        rdx(16'h9000, {1'b0, 8'hBF, 8'h00});
        rdx(16'h9000, {1'b1, 8'hBF, 8'h00});
        done(1'b0);
        rdx(16'h007A, fx(8'hF0));
        rdx(16'h8000, fx(8'hFF));
        rdx(16'hFFFF, fx(8'hFF));
        cpu.op(1'b0, 1'b1, 16'h007A, 8'hA0);
        prog(16'h8000, d);
        rdx(16'h8000, {1'b0, 8'hBF, ~d[7], 7'h00});
        done(1'b1);
        rdx(16'h8000, fx(d));
        prog(16'hC000, d2);
        done(1'b1);
        prog(16'hC001, 8'hF0);
        done(1'b1);
        rdx(16'hC001, fx(8'hF0));
        prog(16'hA000, 8'h00);
        done(1'b1);
        erase(16'hA000, 8'h30);
        cpu.op(1'b0, 1'b1, 16'h8000, 8'h30);
        repeat (2049) cpu.op(1'b0, 1'b0, 16'h0000, 8'h00);
        cpu.op(1'b0, 1'b1, 16'h8000, 8'hB0);
        rdx(16'h007A, {1'b0, 8'h10, 8'h10});
        rdx(16'hC000, fx(d2));
        rdx(16'hA000, {1'b0, 8'hBF, 8'h00});
        repeat (400) cpu.op(1'b0, 1'b0, 16'h0000, 8'h00);
        rdx(16'h007A, {1'b0, 8'h50, 8'h10});
        cpu.op(1'b0, 1'b1, 16'h8000, 8'h30);
        rdx(16'h007A, {1'b0, 8'h50, 8'h00});
        done(1'b1);
        rdx(16'hA000, fx(8'hFF));
        rdx(16'hBFFF, fx(8'hFF));
        rdx(16'hC000, fx(d2));
        rdx(16'h8000, fx(8'hFF));
        rdx(16'hC001, fx(8'hF0));
        repeat (2) cpu.op(1'b0, 1'b0, 16'h0000, 8'h00);
        complete_run;
    end
endmodule
